// file: hdl/ntblp_top.sv
// Translation-table index/data window and page-boundary interrupt request bank.
// Assumes an AXI4-Lite master for software, and a bridge core that reports each
// completed upstream transfer as a one-cycle event with its page number.
//
// Behaviour
// - An 8-bit read/write index selects the table entry by byte offset.
// - Entries are touched only by data window and table offset accesses, never by index writes.
// - A data window write stores valid, prefetch and base fields into the entry.
// - A data window read returns the entry selected by the index.
// - Entry bit 3 marks translated memory prefetchable when set.
// - With 256B granularity, entry bits 24:8 are writable base bits.
// - With 32MB granularity, entry bits 24:8 are reserved and read-only.
// - Bits 31:25 always writable; entries also appear at offsets 100h to 1FFh.
// - Request bit n belongs to page n+1 of the lower range half.
// - A completed transfer to a page's last doubleword sets its request bit.
// - Interrupt is raised while any request bit is set with its mask clear.
// - Forward bridge signals by legacy interrupt A pin or MSI.
// - Reverse bridge signals by INTA assert message or MSI.
// - Writing one clears a request bit, zero leaves it; requests reset to zero.
// - A set mask bit blocks its page's interrupt; masks reset all set.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module ntblp_top (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [11:0]                  s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [11:0]                  s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire ntblp_pkg::ntblp_page_event_type page_event,
    output logic                              irq,
    output logic                              legacy_interrupt_a_pin_out,
    output logic                              legacy_interrupt_a_pin_oe_n,
    output logic                              inta_assert_msg,
    output logic                              inta_deassert_msg,
    output logic                              msi_request
);

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [31:0]                     index_reg;
    logic [31:0]                     mask_reg;
    logic [31:0]                     control_reg;
    logic [31:0]                     request_reg;
    logic [31:0]                     table_mem [ntblp_pkg::NTBLP_ENTRIES];
    logic                            aw_full;
    logic                            w_full;
    logic [11:0]                     aw_addr;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    ntblp_pkg::ntblp_irq_state_type  irq_state;
    ntblp_pkg::ntblp_irq_state_type  next_irq_state;

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are held separately, in either order.

    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs  = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_full && w_full && !s_axi_bvalid;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;

    // Byte lanes turned into a bit mask so every register honours wstrb.
    wire [31:0] strb_bits = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    // Address decode for the held write.
    wire wr_index   = do_write && (aw_addr == ntblp_pkg::NTBLP_ADDR_INDEX);
    wire wr_window  = do_write && (aw_addr == ntblp_pkg::NTBLP_ADDR_WINDOW);
    wire wr_request = do_write && (aw_addr == ntblp_pkg::NTBLP_ADDR_REQUEST);
    wire wr_mask    = do_write && (aw_addr == ntblp_pkg::NTBLP_ADDR_MASK);
    wire wr_control = do_write && (aw_addr == ntblp_pkg::NTBLP_ADDR_CONTROL);
    wire wr_table   = do_write && (aw_addr >= ntblp_pkg::NTBLP_ADDR_TBL_BASE)
                               && (aw_addr <= ntblp_pkg::NTBLP_ADDR_TBL_LAST);
    wire wr_mapped  = wr_index || wr_window || wr_request || wr_mask || wr_control || wr_table;

    // Holding registers block a channel once its beat is taken and free it when the write is performed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_full <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end else if (do_write) begin
                aw_full <= 1'b0;
            end
            if (w_hs) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_full <= 1'b0;
            end
        end
    end

    // Write response one cycle after the write is performed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ntblp_pkg::NTBLP_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? ntblp_pkg::NTBLP_RESP_OKAY : ntblp_pkg::NTBLP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Index, mask and control registers.

    wire gran_32mb = control_reg[ntblp_pkg::NTBLP_CTRL_GRAN_BIT];
    wire reverse   = control_reg[ntblp_pkg::NTBLP_CTRL_REVERSE_BIT];
    wire msi_en    = control_reg[ntblp_pkg::NTBLP_CTRL_MSI_BIT];

    // Index upper bits are never stored, so they read as zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index_reg   <= ntblp_pkg::NTBLP_INDEX_RESET;
            mask_reg    <= ntblp_pkg::NTBLP_MASK_RESET;
            control_reg <= ntblp_pkg::NTBLP_CTRL_RESET;
        end else begin
            if (wr_index) begin
                index_reg <= ((w_data & strb_bits) | (index_reg & ~strb_bits))
                             & ntblp_pkg::NTBLP_INDEX_MASK;
            end
            if (wr_mask) begin
                mask_reg <= (w_data & strb_bits) | (mask_reg & ~strb_bits);
            end
            if (wr_control) begin
                control_reg <= ((w_data & strb_bits) | (control_reg & ~strb_bits))
                               & ntblp_pkg::NTBLP_CTRL_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Translation table.

    // Fine base bits are writable only at 256B granularity; reserved bits never are.
    wire [31:0] entry_rw = gran_32mb ? ntblp_pkg::NTBLP_ENTRY_FIXED_RW
                                     : (ntblp_pkg::NTBLP_ENTRY_FIXED_RW
                                        | ntblp_pkg::NTBLP_ENTRY_FINE_RW);
    wire [5:0]  window_sel = index_reg[7:2];
    wire [5:0]  direct_sel = aw_addr[7:2];
    // The window writes only on its own access; an index write never reaches here.
    wire        tbl_we  = wr_window || wr_table;
    wire [5:0]  tbl_sel = wr_window ? window_sel : direct_sel;
    wire [31:0] tbl_wmask = strb_bits & entry_rw;

    // One entry per loop step; bit 3 carries the prefetchable attribute as written.
    generate
        for (genvar e = 0; e < ntblp_pkg::NTBLP_ENTRIES; e++) begin : g_entry
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    table_mem[e] <= ntblp_pkg::NTBLP_ENTRY_RESET;
                end else if (tbl_we && (tbl_sel == 6'(e))) begin
                    table_mem[e] <= (w_data & tbl_wmask) | (table_mem[e] & ~tbl_wmask);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Page-boundary requests.

    // Only a completed transfer that hits the final doubleword counts.
    wire        page_hit = page_event.done && page_event.last_dword;
    wire [31:0] clr_bits = wr_request ? (w_data & strb_bits) : 32'h0000_0000;

    // Bit n is page n+1; a new event beats a clear in the same cycle.
    generate
        for (genvar p = 0; p < ntblp_pkg::NTBLP_PAGES; p++) begin : g_page
            wire set_bit = page_hit && (page_event.page == 5'(p));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    request_reg[p] <= ntblp_pkg::NTBLP_REQUEST_RESET[p];
                end else if (set_bit) begin
                    request_reg[p] <= 1'b1;
                end else if (clr_bits[p]) begin
                    request_reg[p] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt generation and delivery.

    assign irq = |(request_reg & ~mask_reg);

    // Delivery follows the level: one event on entry, and one on exit for the INTA messages only.
    always_comb begin
        next_irq_state = irq_state;
        case (irq_state)
            ntblp_pkg::NTBLP_IRQ_IDLE: begin
                if (irq) begin
                    next_irq_state = ntblp_pkg::NTBLP_IRQ_ACTIVE;
                end
            end
            ntblp_pkg::NTBLP_IRQ_ACTIVE: begin
                if (!irq) begin
                    next_irq_state = ntblp_pkg::NTBLP_IRQ_IDLE;
                end
            end
            default: begin
                next_irq_state = ntblp_pkg::NTBLP_IRQ_IDLE;
            end
        endcase
    end

    wire rising  = (irq_state == ntblp_pkg::NTBLP_IRQ_IDLE) && irq;
    wire falling = (irq_state == ntblp_pkg::NTBLP_IRQ_ACTIVE) && !irq;

    // Pulses and pin drive are registered so the secondary side sees clean edges.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_state                   <= ntblp_pkg::NTBLP_IRQ_IDLE;
            legacy_interrupt_a_pin_oe_n <= 1'b1;
            inta_assert_msg             <= 1'b0;
            inta_deassert_msg           <= 1'b0;
            msi_request                 <= 1'b0;
        end else begin
            irq_state                   <= next_irq_state;
            legacy_interrupt_a_pin_oe_n <= !(irq && !reverse && !msi_en);
            inta_assert_msg             <= rising && reverse && !msi_en;
            inta_deassert_msg           <= falling && reverse && !msi_en;
            msi_request                 <= rising && msi_en;
        end
    end

    // Open-drain pin only ever pulls low.
    assign legacy_interrupt_a_pin_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, answered the cycle after it is taken.

    assign s_axi_arready = !s_axi_rvalid;
    wire        ar_hs   = s_axi_arvalid && s_axi_arready;
    wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
    wire        rd_tbl  = (rd_addr >= ntblp_pkg::NTBLP_ADDR_TBL_BASE)
                       && (rd_addr <= ntblp_pkg::NTBLP_ADDR_TBL_LAST);
    // Reserved entry bits, and fine base bits at 32MB, read as zero.
    wire [31:0] win_data = table_mem[window_sel] & entry_rw;
    wire [31:0] tbl_data = table_mem[rd_addr[7:2]] & entry_rw;

    logic [31:0] rd_mux;
    logic        rd_ok;

    // Read data select.
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        if (rd_tbl) begin
            rd_mux = tbl_data;
        end else begin
            case (rd_addr)
                ntblp_pkg::NTBLP_ADDR_INDEX:   rd_mux = index_reg;
                ntblp_pkg::NTBLP_ADDR_WINDOW:  rd_mux = win_data;
                ntblp_pkg::NTBLP_ADDR_REQUEST: rd_mux = request_reg;
                ntblp_pkg::NTBLP_ADDR_MASK:    rd_mux = mask_reg;
                ntblp_pkg::NTBLP_ADDR_CONTROL: rd_mux = control_reg;
                default:                       rd_ok  = 1'b0;
            endcase
        end
    end

    // Read data is registered; rvalid holds until rready.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ntblp_pkg::NTBLP_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? ntblp_pkg::NTBLP_RESP_OKAY : ntblp_pkg::NTBLP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// file: hdl/ntblp_pkg.sv
// Package for the bridge translation-table window and page-boundary interrupt bank.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package ntblp_pkg;

    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [11:0] NTBLP_ADDR_INDEX    = 12'h050;
    localparam logic [11:0] NTBLP_ADDR_WINDOW   = 12'h054;
    localparam logic [11:0] NTBLP_ADDR_REQUEST  = 12'h058;
    localparam logic [11:0] NTBLP_ADDR_MASK     = 12'h060;
    localparam logic [11:0] NTBLP_ADDR_CONTROL  = 12'h080;
    localparam logic [11:0] NTBLP_ADDR_TBL_BASE = 12'h100;
    localparam logic [11:0] NTBLP_ADDR_TBL_LAST = 12'h1FF;

    // Bus geometry.
    localparam int          NTBLP_ADDR_W     = 12;
    localparam int          NTBLP_DATA_W     = 32;
    localparam int          NTBLP_ENTRIES    = 64;
    localparam int          NTBLP_PAGES      = 32;
    localparam logic [1:0]  NTBLP_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  NTBLP_RESP_SLVERR = 2'h2;

    // Index register: byte offset in bits 7:0, entry number in bits 7:2.
    localparam logic [31:0] NTBLP_INDEX_MASK  = 32'h0000_00FF;
    localparam logic [31:0] NTBLP_INDEX_RESET = 32'h0000_0000;

    // Entry fields: valid bit 0, prefetchable bit 3, base 24:8 and 31:25.
    localparam int          NTBLP_ENTRY_VALID_BIT = 0;
    localparam int          NTBLP_ENTRY_PREF_BIT  = 3;
    localparam logic [31:0] NTBLP_ENTRY_FIXED_RW  = 32'hFE00_0009;
    localparam logic [31:0] NTBLP_ENTRY_FINE_RW   = 32'h01FF_FF00;
    localparam logic [31:0] NTBLP_ENTRY_RESET     = 32'h0000_0000;

    // Page-boundary request and mask resets.
    localparam logic [31:0] NTBLP_REQUEST_RESET = 32'h0000_0000;
    localparam logic [31:0] NTBLP_MASK_RESET    = 32'hFFFF_FFFF;

    // Control register fields.
    localparam int          NTBLP_CTRL_GRAN_BIT    = 0;
    localparam int          NTBLP_CTRL_REVERSE_BIT = 1;
    localparam int          NTBLP_CTRL_MSI_BIT     = 2;
    localparam logic [31:0] NTBLP_CTRL_MASK        = 32'h0000_0007;
    localparam logic [31:0] NTBLP_CTRL_RESET       = 32'h0000_0000;

    // One completed upstream transfer seen by the bridge core.
    typedef struct packed {
        logic       done;
        logic       last_dword;
        logic [4:0] page;
    } ntblp_page_event_type;

    // Interrupt delivery state.
    typedef enum logic [0:0] {
        NTBLP_IRQ_IDLE,
        NTBLP_IRQ_ACTIVE
    } ntblp_irq_state_type;

endpackage

// file: tb/ntblp_top_props.sv
// Port checker for the lookup window and page-boundary interrupt bank.
// Assumes one clock and a synchronous active-low reset; bound to ntblp_top.
`timescale 1ns/1ps

module ntblp_top_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        irq,
    input wire logic        legacy_interrupt_a_pin_out,
    input wire logic        legacy_interrupt_a_pin_oe_n,
    input wire logic        inta_assert_msg,
    input wire logic        inta_deassert_msg,
    input wire logic        msi_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    // Bus answers: a taken read answers next cycle and both answers hold until taken.
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");

    ////////////////////////////////////////////////////////////////////////////
    // Delivery: every rise of irq is delivered one cycle later; messages only follow an edge of irq, the pin only a set irq.
    irq_delivered_a: assert property (
        $rose(irq) |=> msi_request || inta_assert_msg || !legacy_interrupt_a_pin_oe_n)
        else $error("interrupt not delivered");
    pin_value_a: assert property (legacy_interrupt_a_pin_out == 1'b0)
        else $error("pin drives high");
    pin_cause_a: assert property (!legacy_interrupt_a_pin_oe_n |-> $past(irq))
        else $error("pin pulled without interrupt");
    msi_cause_a: assert property (msi_request |-> $past(irq) && !$past(irq, 2))
        else $error("message signalled without rise");
    assert_cause_a: assert property (inta_assert_msg |-> $past(irq) && !$past(irq, 2))
        else $error("assert message without rise");
    deassert_cause_a: assert property (
        inta_deassert_msg |-> !$past(irq) && $past(irq, 2))
        else $error("deassert message without fall");
endmodule

bind ntblp_top ntblp_top_props ntblp_top_props_inst (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .irq,
    .legacy_interrupt_a_pin_out, .legacy_interrupt_a_pin_oe_n, .inta_assert_msg,
    .inta_deassert_msg, .msi_request
);

// file: tb/ntblp_core_model.sv
// Model of the bridge core that reports completed upstream transfers.
// Assumes the bench commands each report one cycle ahead on the same clock.
`timescale 1ns/1ps

module ntblp_core_model (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  fire,
    input wire logic                  last,
    input wire logic [4:0]            page,
    output ntblp_pkg::ntblp_page_event_type page_event
);
    // One-cycle report; between reports the page field keeps changing so the
    // block cannot lean on a stale page number.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_event <= '0;
        end else if (fire) begin
            page_event <= '{done: 1'b1, last_dword: last, page: page};
        end else begin
            page_event <= '{done: 1'b0, last_dword: 1'b0, page: ~page_event.page};
        end
    end
endmodule

// file: tb/tb_ntblp_lookup_and_page_irq.sv
// Self-checking bench for the lookup window and page-boundary interrupt bank.
// Assumes an AXI4-Lite master in the bench and the core model as event source.
`timescale 1ns/1ps

module tb_ntb_lookup_and_page_irq;
    localparam logic [11:0] A_IDX = ntblp_pkg::NTBLP_ADDR_INDEX;
    localparam logic [11:0] A_WIN = ntblp_pkg::NTBLP_ADDR_WINDOW;
    localparam logic [11:0] A_REQ = ntblp_pkg::NTBLP_ADDR_REQUEST;
    localparam logic [11:0] A_MSK = ntblp_pkg::NTBLP_ADDR_MASK;
    localparam logic [11:0] A_CTL = ntblp_pkg::NTBLP_ADDR_CONTROL;
    logic [11:0] a_list [5] = '{A_IDX, A_WIN, A_REQ, A_MSK, A_CTL};
    logic        aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, lst = 1'b0;
    logic [4:0]  pg = 5'h0, p;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, m_idx, m_req, m_mask, m_ctrl, m_tbl [64];
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        irq, legacy_interrupt_a_pin_out, legacy_interrupt_a_pin_oe_n;
    logic        inta_assert_msg, inta_deassert_msg, msi_request;
    int          mismatches = 0, n_checks = 0, n_msi = 0, n_am = 0, n_dm = 0, i, k, a0, s0, d0;
    ntblp_pkg::ntblp_page_event_type page_event;

    ntblp_top ntblp_top_inst (.*);
    ntblp_core_model ntblp_core_model_inst (.aclk, .aresetn, .fire, .last(lst), .page(pg),
                                            .page_event);

    always #4 aclk = ~aclk;

    // Count delivery pulses; they last one cycle so a later look would miss them.
    always @(posedge aclk) begin
        n_msi += msi_request;
        n_am += inta_assert_msg;
        n_dm += inta_deassert_msg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference model of the registers.
    function automatic logic [31:0] wm();
        return ntblp_pkg::NTBLP_ENTRY_FIXED_RW | (m_ctrl[0] ? '0 : ntblp_pkg::NTBLP_ENTRY_FINE_RW);
    endfunction
    function automatic logic [33:0] mrd(input logic [11:0] a);
        case (a)
            A_IDX: return {2'h0, m_idx};
            A_WIN: return {2'h0, m_tbl[m_idx[7:2]] & wm()};
            A_REQ: return {2'h0, m_req};
            A_MSK: return {2'h0, m_mask};
            A_CTL: return {2'h0, m_ctrl};
            default: return (a[11:8] == 4'h1) ? {2'h0, m_tbl[a[7:2]] & wm()} : {2'h2, 32'h0};
        endcase
    endfunction
    task automatic mwr(input logic [11:0] a, input logic [31:0] d);
        logic [5:0] e;
        e = (a == A_WIN) ? m_idx[7:2] : a[7:2];
        if (a == A_IDX) m_idx = d & ntblp_pkg::NTBLP_INDEX_MASK;
        else if (a == A_REQ) m_req = m_req & ~d;
        else if (a == A_MSK) m_mask = d;
        else if (a == A_CTL) m_ctrl = d & ntblp_pkg::NTBLP_CTRL_MASK;
        else if (a == A_WIN || a[11:8] == 4'h1) m_tbl[e] = (m_tbl[e] & ~wm()) | (d & wm());
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Checking, bus tasks and closing.
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic ck_irq();
        #1 chk("irq", {31'h0, irq}, {31'h0, |(m_req & ~m_mask)});
    endtask
    // Valid and ready are sampled at the falling edge, which equals their value at the next
    // rising edge because everything here moves on rising edges only.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [33:0] r;
        logic        ta, tw, tb;
        logic [1:0]  rs;
        r = mrd(a);
        mwr(a, d);
        tb = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        s_axi_bready <= 1'($urandom);
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            s_axi_bready <= !tb;
        end
        chk("bresp", {30'h0, rs}, {30'h0, r[33:32]});
    endtask
    task automatic rd(input logic [11:0] a);
        logic [33:0] r;
        logic        ta, tr;
        logic [31:0] d;
        logic [1:0]  rs;
        r = mrd(a);
        tr = 1'b0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        s_axi_rready <= 1'($urandom);
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            {d, rs} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            s_axi_rready <= !tr;
        end
        chk("rdata", d, r[31:0]);
        chk("rresp", {30'h0, rs}, {30'h0, r[33:32]});
    endtask
    task automatic ev(input logic [4:0] pp, input logic l);
        @(posedge aclk);
        {fire, pg, lst} <= {1'b1, pp, l};
        @(posedge aclk);
        fire <= 1'b0;
        repeat (3) @(posedge aclk);
        if (l) m_req[pp] = 1'b1;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // The whole sequence needs about a thousand cycles; this cuts a hang short.
    initial begin
        repeat (30000) @(posedge aclk);
        mismatches++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(32'h55f91b89));
        {m_idx, m_req, m_ctrl} = {3{32'h0}};
        m_mask = ntblp_pkg::NTBLP_MASK_RESET;
        foreach (m_tbl[j]) m_tbl[j] = ntblp_pkg::NTBLP_ENTRY_RESET;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (a_list[j]) rd(a_list[j]);
        rd(12'h0C0);
        wr(12'h0C0, $urandom);
        // Index first, then the window; the granularity flips halfway.
        for (i = 0; i < 16; i++) begin
            if (i == 8) wr(A_CTL, 32'h1);
            wr(A_IDX, $urandom);
            wr(A_WIN, $urandom);
            rd(A_WIN);
            rd(A_IDX);
        end
        wr(12'h1FC, $urandom);
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 64; i++) rd(12'h100 + 12'(4 * i));
            wr(A_CTL, 32'h0);
        end
        wr(A_MSK, 32'h0);
        // Forward pin, reverse message and message-signalled delivery in turn.
        for (k = 0; k < 3; k++) begin
            wr(A_CTL, 32'(2 * k));
            p = (k == 0) ? 5'd0 : (k == 1) ? 5'd31 : 5'($urandom);
            ev(p, 1'b0);
            rd(A_REQ);
            {a0, s0, d0} = {n_am, n_msi, n_dm};
            ev(p, 1'b1);
            rd(A_REQ);
            ck_irq();
            chk("oe_n", {31'h0, legacy_interrupt_a_pin_oe_n}, {31'h0, k != 0});
            chk("assert_msg", 32'(n_am - a0), {31'h0, k == 1});
            chk("msi", 32'(n_msi - s0), {31'h0, k == 2});
            wr(A_REQ, 32'h0);
            rd(A_REQ);
            wr(A_REQ, 32'h1 << p);
            rd(A_REQ);
            ck_irq();
            repeat (2) @(posedge aclk);
            chk("deassert_msg", 32'(n_dm - d0), {31'h0, k == 1});
            chk("oe_n", {31'h0, legacy_interrupt_a_pin_oe_n}, 32'h1);
        end
        // A masked request waits until its mask bit is cleared.
        wr(A_MSK, 32'hFFFFFFFF);
        ev(5'd5, 1'b1);
        ck_irq();
        rd(A_REQ);
        wr(A_MSK, ~32'h20);
        ck_irq();
        wr(A_REQ, 32'hFFFFFFFF);
        ck_irq();
        end_sim();
    end
endmodule
